// File: design/fcs_pkg.sv
// Package for the flash command sequencer host: codes, addresses, command set and carriers
package fcs_pkg;

    // Bus cycle data codes
    localparam logic [7:0] CD_UNLOCK1 = 8'hAA;
    localparam logic [7:0] CD_UNLOCK2 = 8'h55;
    localparam logic [7:0] CD_PROGRAM = 8'hA0;
    localparam logic [7:0] CD_BUF_LOAD = 8'h25;
    localparam logic [7:0] CD_BUF_CONFIRM = 8'h29;
    localparam logic [7:0] CD_RESET = 8'hF0;
    localparam logic [7:0] CD_ERASE_SETUP = 8'h80;
    localparam logic [7:0] CD_CHIP_ERASE = 8'h10;
    localparam logic [7:0] CD_SECTOR_ERASE = 8'h30;
    localparam logic [7:0] CD_QUERY = 8'h98;
    localparam logic [7:0] CD_SUSPEND = 8'hB0;
    localparam logic [7:0] CD_RESUME = 8'h30;
    localparam logic [7:0] CD_DPD_ENTER = 8'hB9;
    localparam logic [7:0] CD_DPD_EXIT = 8'hAB;
    localparam logic [7:0] CD_LOCKREG_ENTER = 8'h40;
    localparam logic [7:0] CD_NVPROT_ENTER = 8'hC0;
    localparam logic [7:0] CD_FREEZE_ENTER = 8'h50;
    localparam logic [7:0] CD_SET_EXIT1 = 8'h90;
    localparam logic [7:0] CD_ZERO = 8'h00;

    // Unlock and query addresses, word mode and byte mode, and the zero address
    localparam logic [11:0] AD_W_UNLOCK1 = 12'h555;
    localparam logic [11:0] AD_W_UNLOCK2 = 12'h2AA;
    localparam logic [11:0] AD_B_UNLOCK1 = 12'hAAA;
    localparam logic [11:0] AD_B_UNLOCK2 = 12'h555;
    localparam logic [11:0] AD_W_QUERY = 12'h055;
    localparam logic [11:0] AD_B_QUERY = 12'h0AA;
    localparam logic [11:0] AD_ZERO = 12'h000;

    // Protection status encodings
    localparam logic [7:0] ST_PROTECTED = 8'h00;
    localparam logic [7:0] ST_UNPROTECTED = 8'h01;

    // Bus strobe length in clock cycles
    localparam int STROBE_CYCLES = 2;

    // Host commands
    typedef enum logic [4:0] {
        FCS_CMD_PROGRAM = 5'h00,
        FCS_CMD_BUF_PROGRAM = 5'h01,
        FCS_CMD_BUF_ABORT = 5'h02,
        FCS_CMD_CHIP_ERASE = 5'h03,
        FCS_CMD_SECTOR_ERASE = 5'h04,
        FCS_CMD_QUERY = 5'h05,
        FCS_CMD_SUSPEND = 5'h06,
        FCS_CMD_RESUME = 5'h07,
        FCS_CMD_DPD_ENTER = 5'h08,
        FCS_CMD_DPD_EXIT = 5'h09,
        FCS_CMD_RESET = 5'h0A,
        FCS_CMD_LOCKREG_ENTER = 5'h0B,
        FCS_CMD_LOCKREG_PROGRAM = 5'h0C,
        FCS_CMD_SET_EXIT = 5'h0D,
        FCS_CMD_NVPROT_ENTER = 5'h0E,
        FCS_CMD_NVPROT_SET = 5'h0F,
        FCS_CMD_NVPROT_ERASE_ALL = 5'h10,
        FCS_CMD_FREEZE_ENTER = 5'h11,
        FCS_CMD_FREEZE_SET = 5'h12,
        FCS_CMD_READ = 5'h13
    } fcs_cmd_e;

    // One request from the user side
    typedef struct packed {
        fcs_cmd_e cmd;
        logic [23:0] addr;
        logic [15:0] data;
        logic [7:0] count_m1;
    } fcs_req_s;

    // One bus cycle handed to the pin driver
    typedef struct packed {
        logic is_read;
        logic [23:0] addr;
        logic [15:0] data;
    } fcs_cyc_s;

endpackage

// File: design/fcs_bus_cycle.sv
// Pin driver: turns one bus cycle into a write or read strobe on the flash pins
module fcs_bus_cycle #(
    parameter int STROBE = fcs_pkg::STROBE_CYCLES
) (
    input wire logic mclk_in,
    input wire logic rst_in,
    input wire logic cyc_valid_in,
    input fcs_pkg::fcs_cyc_s cyc_in,
    output logic cyc_ready_out,
    output logic rd_valid_out,
    output logic [15:0] rd_data_out,
    output logic [23:0] addr_out,
    output logic ce_n_out,
    output logic we_n_out,
    output logic oe_n_out,
    output logic [15:0] dq_out,
    output logic dq_oe_out,
    input wire logic [15:0] dq_in
);

    initial begin
        if (STROBE < 1 || STROBE > 255) $error("fcs_bus_cycle: STROBE out of range");
    end

    logic [7:0] cnt_r;
    logic busy_r;
    logic rd_r;

    assign cyc_ready_out = !busy_r;

    // Strobe sequencer: pins stay asserted for STROBE cycles, then one idle cycle
    always_ff @(posedge mclk_in or posedge rst_in) begin
        if (rst_in) begin
            busy_r <= 1'b0;
            cnt_r <= 8'h00;
            rd_r <= 1'b0;
            addr_out <= 24'h000000;
            dq_out <= 16'h0000;
            dq_oe_out <= 1'b0;
            ce_n_out <= 1'b1;
            we_n_out <= 1'b1;
            oe_n_out <= 1'b1;
        end else if (!busy_r) begin
            if (cyc_valid_in) begin
                busy_r <= 1'b1;
                cnt_r <= 8'(STROBE);
                rd_r <= cyc_in.is_read;
                addr_out <= cyc_in.addr;
                dq_out <= cyc_in.data;
                dq_oe_out <= !cyc_in.is_read;
                ce_n_out <= 1'b0;
                we_n_out <= cyc_in.is_read;
                oe_n_out <= !cyc_in.is_read;
            end
        end else if (cnt_r != 8'h00) begin
            cnt_r <= cnt_r - 8'h01;
            // Write data latches on the rising write strobe, so release it here
            if (cnt_r == 8'h01) begin
                ce_n_out <= 1'b1;
                we_n_out <= 1'b1;
                oe_n_out <= 1'b1;
            end
        end else begin
            busy_r <= 1'b0;
            dq_oe_out <= 1'b0; // Hold data one cycle past the strobe edge
        end
    end

    // Read data is sampled on the last strobe cycle
    always_ff @(posedge mclk_in or posedge rst_in) begin
        if (rst_in) begin
            rd_valid_out <= 1'b0;
            rd_data_out <= 16'h0000;
        end else begin
            rd_valid_out <= busy_r && rd_r && cnt_r == 8'h01;
            if (busy_r && rd_r && cnt_r == 8'h01) begin
                rd_data_out <= dq_in;
            end
        end
    end

endmodule

// File: design/fcs_host.sv
// Host-side command sequencer that drives flash command sequences on the parallel bus
// Summary of operation
// - Program: two unlocks, A0, then target/payload
// - Buffered program: unlocks, 25, count, then pairs
// - Count cycle carries words minus one
// - 29 to sector commits; unlock F0 aborts
// - Erase: unlock, 80, unlock, 10 or 30
// - Write 98 at query address enters query
// - B0 suspends, 30 resumes, any address
// - Deep power-down: unlocks, B9; AB exits
// - Unlocks, 40 enter lock register; A0, data
// - Lock register readable; 90 then 00 exits
// - Unlocks then C0 enter nonvolatile protection set
// - A0/00 sets bit, 80/30 erases, read status
// - 90 then 00 leaves nonvolatile protection set
// - Query mode lasts until reset command
// - F0 anywhere resets to read array
module fcs_host #(
    parameter int MAX_BUF_WORDS = 32
) (
    input wire logic mclk_in,
    input wire logic rst_in,
    input wire logic byte_mode_in,
    input wire logic req_valid_in,
    input fcs_pkg::fcs_req_s req_in,
    output logic req_ready_out,
    input wire logic buf_valid_in,
    input wire logic [23:0] buf_addr_in,
    input wire logic [15:0] buf_data_in,
    output logic buf_ready_out,
    output logic done_out,
    output logic [15:0] rd_data_out,
    output logic prot_status_out,
    output logic [23:0] addr_out,
    output logic ce_n_out,
    output logic we_n_out,
    output logic oe_n_out,
    output logic [15:0] dq_out,
    output logic dq_oe_out,
    input wire logic [15:0] dq_in
);

    initial begin
        if (MAX_BUF_WORDS < 1 || MAX_BUF_WORDS > 256) $error("fcs_host: MAX_BUF_WORDS out of range");
    end

    ////////////////////////////////////////////////////////////////////////
    // Sequencer state

    typedef enum logic [2:0] {
        FCS_IDLE = 3'b000,
        FCS_ISSUE = 3'b001,
        FCS_BUF_DATA = 3'b011,
        FCS_WAIT_READ = 3'b010,
        FCS_FINISH = 3'b110
    } fcs_state_e;

    fcs_state_e state_r;
    fcs_pkg::fcs_req_s req_r;
    logic [2:0] step_r;
    logic [2:0] last_step_r;
    logic [8:0] words_left_r;
    logic byte_r;

    logic cyc_valid;
    logic cyc_ready;
    fcs_pkg::fcs_cyc_s cyc;
    logic rd_valid;
    logic [15:0] rd_data;

    // Unlock address for cycle 1 or 2: 555/2AA in word mode, AAA/555 in byte mode
    function automatic logic [23:0] unlock_addr(input logic second, input logic bmode);
        logic [11:0] a;
        a = second ? (bmode ? fcs_pkg::AD_B_UNLOCK2 : fcs_pkg::AD_W_UNLOCK2)
                   : (bmode ? fcs_pkg::AD_B_UNLOCK1 : fcs_pkg::AD_W_UNLOCK1);
        return {12'h000, a};
    endfunction

    function automatic fcs_pkg::fcs_cyc_s wr(input logic [23:0] a, input logic [7:0] d);
        return '{is_read: 1'b0, addr: a, data: {8'h00, d}};
    endfunction

    // Number of cycles (minus one) in each command's fixed part
    function automatic logic [2:0] cmd_last(input fcs_pkg::fcs_cmd_e c);
        case (c)
            fcs_pkg::FCS_CMD_PROGRAM: cmd_last = 3'h3;
            fcs_pkg::FCS_CMD_BUF_PROGRAM: cmd_last = 3'h3;
            fcs_pkg::FCS_CMD_CHIP_ERASE,
            fcs_pkg::FCS_CMD_SECTOR_ERASE: cmd_last = 3'h5;
            fcs_pkg::FCS_CMD_BUF_ABORT, fcs_pkg::FCS_CMD_DPD_ENTER,
            fcs_pkg::FCS_CMD_LOCKREG_ENTER, fcs_pkg::FCS_CMD_NVPROT_ENTER,
            fcs_pkg::FCS_CMD_FREEZE_ENTER: cmd_last = 3'h2;
            fcs_pkg::FCS_CMD_LOCKREG_PROGRAM, fcs_pkg::FCS_CMD_SET_EXIT,
            fcs_pkg::FCS_CMD_NVPROT_SET, fcs_pkg::FCS_CMD_NVPROT_ERASE_ALL,
            fcs_pkg::FCS_CMD_FREEZE_SET: cmd_last = 3'h1;
            default: cmd_last = 3'h0;
        endcase
    endfunction

    ////////////////////////////////////////////////////////////////////////
    // Cycle table: address and data of step step_r for the held request

    always_comb begin
        logic [23:0] u1;
        logic [23:0] u2;
        logic [7:0] c3;
        u1 = unlock_addr(1'b0, byte_r);
        u2 = unlock_addr(1'b1, byte_r);
        c3 = fcs_pkg::CD_ZERO;
        cyc = wr(u1, fcs_pkg::CD_UNLOCK1);
        case (req_r.cmd)
            fcs_pkg::FCS_CMD_PROGRAM, fcs_pkg::FCS_CMD_BUF_ABORT, fcs_pkg::FCS_CMD_DPD_ENTER,
            fcs_pkg::FCS_CMD_LOCKREG_ENTER, fcs_pkg::FCS_CMD_NVPROT_ENTER,
            fcs_pkg::FCS_CMD_FREEZE_ENTER: begin
                case (req_r.cmd)
                    fcs_pkg::FCS_CMD_PROGRAM: c3 = fcs_pkg::CD_PROGRAM;
                    fcs_pkg::FCS_CMD_BUF_ABORT: c3 = fcs_pkg::CD_RESET;
                    fcs_pkg::FCS_CMD_DPD_ENTER: c3 = fcs_pkg::CD_DPD_ENTER;
                    fcs_pkg::FCS_CMD_LOCKREG_ENTER: c3 = fcs_pkg::CD_LOCKREG_ENTER;
                    fcs_pkg::FCS_CMD_NVPROT_ENTER: c3 = fcs_pkg::CD_NVPROT_ENTER;
                    fcs_pkg::FCS_CMD_FREEZE_ENTER: c3 = fcs_pkg::CD_FREEZE_ENTER;
                    default: c3 = fcs_pkg::CD_ZERO;
                endcase
                case (step_r)
                    3'h0: cyc = wr(u1, fcs_pkg::CD_UNLOCK1);
                    3'h1: cyc = wr(u2, fcs_pkg::CD_UNLOCK2);
                    3'h2: cyc = wr(u1, c3);
                    default: cyc = '{is_read: 1'b0, addr: req_r.addr, data: req_r.data};
                endcase
            end
            fcs_pkg::FCS_CMD_BUF_PROGRAM: begin
                case (step_r)
                    3'h0: cyc = wr(u1, fcs_pkg::CD_UNLOCK1);
                    3'h1: cyc = wr(u2, fcs_pkg::CD_UNLOCK2);
                    3'h2: cyc = wr(req_r.addr, fcs_pkg::CD_BUF_LOAD);
                    3'h3: cyc = wr(req_r.addr, req_r.count_m1);
                    default: cyc = wr(req_r.addr, fcs_pkg::CD_BUF_CONFIRM);
                endcase
            end
            fcs_pkg::FCS_CMD_CHIP_ERASE, fcs_pkg::FCS_CMD_SECTOR_ERASE: begin
                case (step_r)
                    3'h0, 3'h3: cyc = wr(u1, fcs_pkg::CD_UNLOCK1);
                    3'h1, 3'h4: cyc = wr(u2, fcs_pkg::CD_UNLOCK2);
                    3'h2: cyc = wr(u1, fcs_pkg::CD_ERASE_SETUP);
                    default: cyc = (req_r.cmd == fcs_pkg::FCS_CMD_CHIP_ERASE)
                        ? wr(u1, fcs_pkg::CD_CHIP_ERASE) : wr(req_r.addr, fcs_pkg::CD_SECTOR_ERASE);
                endcase
            end
            fcs_pkg::FCS_CMD_QUERY:
                cyc = wr({12'h000, byte_r ? fcs_pkg::AD_B_QUERY : fcs_pkg::AD_W_QUERY}, fcs_pkg::CD_QUERY);
            fcs_pkg::FCS_CMD_SUSPEND: cyc = wr(req_r.addr, fcs_pkg::CD_SUSPEND);
            fcs_pkg::FCS_CMD_RESUME: cyc = wr(req_r.addr, fcs_pkg::CD_RESUME);
            fcs_pkg::FCS_CMD_DPD_EXIT: cyc = wr(req_r.addr, fcs_pkg::CD_DPD_EXIT);
            fcs_pkg::FCS_CMD_RESET: cyc = wr(req_r.addr, fcs_pkg::CD_RESET);
            fcs_pkg::FCS_CMD_LOCKREG_PROGRAM, fcs_pkg::FCS_CMD_FREEZE_SET, fcs_pkg::FCS_CMD_NVPROT_SET:
                cyc = (step_r == 3'h0) ? wr(req_r.addr, fcs_pkg::CD_PROGRAM)
                    : (req_r.cmd == fcs_pkg::FCS_CMD_LOCKREG_PROGRAM)
                    ? '{is_read: 1'b0, addr: req_r.addr, data: req_r.data}
                    : wr(req_r.addr, fcs_pkg::CD_ZERO);
            fcs_pkg::FCS_CMD_NVPROT_ERASE_ALL:
                cyc = (step_r == 3'h0) ? wr(req_r.addr, fcs_pkg::CD_ERASE_SETUP)
                    : wr({12'h000, fcs_pkg::AD_ZERO}, fcs_pkg::CD_SECTOR_ERASE);
            fcs_pkg::FCS_CMD_SET_EXIT:
                cyc = wr(req_r.addr, (step_r == 3'h0) ? fcs_pkg::CD_SET_EXIT1 : fcs_pkg::CD_ZERO);
            fcs_pkg::FCS_CMD_READ: cyc = '{is_read: 1'b1, addr: req_r.addr, data: 16'h0000};
            default: cyc = wr(req_r.addr, fcs_pkg::CD_RESET);
        endcase
        if (state_r == FCS_BUF_DATA) begin
            cyc = '{is_read: 1'b0, addr: buf_addr_in, data: buf_data_in};
        end
    end

    assign cyc_valid = (state_r == FCS_ISSUE) || (state_r == FCS_BUF_DATA && buf_valid_in);
    assign buf_ready_out = (state_r == FCS_BUF_DATA) && cyc_ready;
    assign req_ready_out = (state_r == FCS_IDLE);

    ////////////////////////////////////////////////////////////////////////
    // Sequencing: whole command issued before the next request is taken (buffer words wait on buf_valid_in), so the device never sees a broken sequence

    always_ff @(posedge mclk_in or posedge rst_in) begin
        if (rst_in) begin
            state_r <= FCS_IDLE;
            req_r <= '0;
            step_r <= 3'h0;
            last_step_r <= 3'h0;
            words_left_r <= 9'h000;
            byte_r <= 1'b0;
        end else begin
            case (state_r)
                FCS_IDLE: begin
                    if (req_valid_in) begin
                        req_r <= req_in;
                        byte_r <= byte_mode_in;
                        step_r <= 3'h0;
                        last_step_r <= cmd_last(req_in.cmd);
                        // Words sent are clamped to the buffer depth the device accepts; the count cycle still carries count_m1
                        words_left_r <= (req_in.count_m1 >= 8'(MAX_BUF_WORDS)) ? 9'(MAX_BUF_WORDS)
                            : 9'({1'b0, req_in.count_m1} + 9'h001);
                        state_r <= FCS_ISSUE;
                    end
                end
                FCS_ISSUE: begin
                    if (cyc_ready) begin
                        if (cyc.is_read) begin
                            state_r <= FCS_WAIT_READ;
                        end else if (req_r.cmd == fcs_pkg::FCS_CMD_BUF_PROGRAM && step_r == 3'h3) begin
                            state_r <= FCS_BUF_DATA;
                        end else if (step_r >= last_step_r) begin
                            state_r <= FCS_FINISH;
                        end else begin
                            step_r <= step_r + 3'h1;
                        end
                    end
                end
                FCS_BUF_DATA: begin
                    if (buf_valid_in && cyc_ready) begin
                        words_left_r <= words_left_r - 9'h001;
                        if (words_left_r == 9'h001) begin
                            step_r <= 3'h4;
                            state_r <= FCS_ISSUE; // Confirm follows last location
                        end
                    end
                end
                FCS_WAIT_READ: begin
                    if (rd_valid) begin
                        state_r <= FCS_FINISH;
                    end
                end
                FCS_FINISH: state_r <= FCS_IDLE;
                default: state_r <= FCS_IDLE;
            endcase
        end
    end

    // Completion pulse and read result; status bit is high when protected
    always_ff @(posedge mclk_in or posedge rst_in) begin
        if (rst_in) begin
            done_out <= 1'b0;
            rd_data_out <= 16'h0000;
            prot_status_out <= 1'b0;
        end else begin
            done_out <= (state_r == FCS_FINISH);
            if (rd_valid) begin
                rd_data_out <= rd_data;
                prot_status_out <= (rd_data[7:0] == fcs_pkg::ST_PROTECTED);
            end
        end
    end

    fcs_bus_cycle u_bus (
        .mclk_in(mclk_in),
        .rst_in(rst_in),
        .cyc_valid_in(cyc_valid),
        .cyc_in(cyc),
        .cyc_ready_out(cyc_ready),
        .rd_valid_out(rd_valid),
        .rd_data_out(rd_data),
        .addr_out(addr_out),
        .ce_n_out(ce_n_out),
        .we_n_out(we_n_out),
        .oe_n_out(oe_n_out),
        .dq_out(dq_out),
        .dq_oe_out(dq_oe_out),
        .dq_in(dq_in)
    );

endmodule

// File: bench/fcs_host_chk.sv
// Checker for the pins and handshakes of the flash command sequencer host
module fcs_host_chk (
    input wire logic mclk_in,
    input wire logic rst_in,
    input wire logic req_valid_in,
    input wire logic req_ready_out,
    input wire logic done_out,
    input wire logic [23:0] addr_out,
    input wire logic ce_n_out,
    input wire logic we_n_out,
    input wire logic oe_n_out,
    input wire logic [15:0] dq_out,
    input wire logic dq_oe_out
);
    default clocking cb @(posedge mclk_in);
    endclocking
    default disable iff (rst_in);

    ////////////////////////////////////////////////////////////////////////////////
    // Strobes two clocks wide: one edge per cycle
    AST_WE_WIDTH: assert property ($fell(we_n_out) |=> !we_n_out ##1 we_n_out)
        else $error("write strobe width wrong");
    AST_OE_WIDTH: assert property ($fell(oe_n_out) |=> !oe_n_out ##1 oe_n_out)
        else $error("read strobe width wrong");
    // Read and write at once would fight
    AST_NO_CLASH: assert property (!(we_n_out == 1'b0 && oe_n_out == 1'b0))
        else $error("read and write strobes low together");
    AST_WR_DRIVES: assert property (!we_n_out |-> dq_oe_out && !ce_n_out)
        else $error("write cycle without driven data or select");
    AST_RD_RELEASES: assert property (!oe_n_out |-> !dq_oe_out && !ce_n_out)
        else $error("read cycle with host driving data");
    // Address and data outlast the rising strobe
    AST_WR_HOLD: assert property ($rose(we_n_out) |-> $stable(addr_out) && $stable(dq_out) ##1 !dq_oe_out)
        else $error("write hold violated");
    AST_DONE_ONE: assert property (done_out |=> !done_out)
        else $error("done longer than one clock");
    AST_BUSY_AFTER_TAKE: assert property (req_valid_in && req_ready_out |=> !req_ready_out)
        else $error("request accepted but still ready");
    AST_DONE_BOUND: assert property (req_valid_in && req_ready_out |-> ##[4:400] done_out)
        else $error("command did not complete in time");

    CV_WRITE: cover property ($fell(we_n_out));
    CV_READ: cover property ($fell(oe_n_out));
    CV_DONE: cover property (done_out);
endmodule

bind fcs_host fcs_host_chk u_chk (
    .mclk_in(mclk_in), .rst_in(rst_in), .req_valid_in(req_valid_in), .req_ready_out(req_ready_out),
    .done_out(done_out), .addr_out(addr_out), .ce_n_out(ce_n_out), .we_n_out(we_n_out),
    .oe_n_out(oe_n_out), .dq_out(dq_out), .dq_oe_out(dq_oe_out)
);

// File: bench/fcs_flash_model.sv
// Behavioural flash device: logs write cycles and answers status reads
module fcs_flash_model (
    input wire logic mclk_in,
    input wire logic [23:0] addr_in,
    input wire logic ce_n_in,
    input wire logic we_n_in,
    input wire logic oe_n_in,
    input wire logic [15:0] dq_in,
    input wire logic dq_oe_in,
    output logic [15:0] dq_out
);
    timeunit 1ns;
    timeprecision 1ps;
    logic [39:0] log_q[$];
    logic [15:0] lock_r = 16'h0001;
    logic we_q = 1'b1;

    ////////////////////////////////////////////////////////////////////////////////
    // One log entry per falling write strobe
    always @(posedge mclk_in) begin
        if (!ce_n_in && !we_n_in && we_q && dq_oe_in) begin
            log_q.push_back({addr_in, dq_in});
        end
        we_q <= we_n_in;
    end
    // Released bus shows the inverse, so a late sample never matches
    assign dq_out = (!ce_n_in && !oe_n_in) ? lock_r : ~lock_r;
endmodule

// File: bench/fcs_host_tb.sv
// Testbench for the flash command sequencer host
module fcs_host_tb;
    timeunit 1ns;
    timeprecision 1ps;
    logic mclk_in = 1'b0;
    logic rst_in = 1'b1;
    logic byte_mode_in = 1'b0;
    logic req_valid_in = 1'b0;
    fcs_pkg::fcs_req_s req_in = '0;
    logic buf_valid_in = 1'b0;
    logic [23:0] buf_addr_in = 24'h000000;
    logic [15:0] buf_data_in = 16'h0000;
    logic req_ready_out, buf_ready_out, done_out, prot_status_out, ce_n_out, we_n_out, oe_n_out, dq_oe_out;
    logic [15:0] rd_data_out, dq_out, dq_in;
    logic [23:0] addr_out;
    logic [39:0] exp_q[$];
    int n_errors = 0;
    int n_checks = 0;
    int cycles = 0;

    fcs_host #(.MAX_BUF_WORDS(32)) dut (
        .mclk_in(mclk_in), .rst_in(rst_in), .byte_mode_in(byte_mode_in), .req_valid_in(req_valid_in),
        .req_in(req_in), .req_ready_out(req_ready_out), .buf_valid_in(buf_valid_in),
        .buf_addr_in(buf_addr_in), .buf_data_in(buf_data_in), .buf_ready_out(buf_ready_out),
        .done_out(done_out), .rd_data_out(rd_data_out), .prot_status_out(prot_status_out),
        .addr_out(addr_out), .ce_n_out(ce_n_out), .we_n_out(we_n_out), .oe_n_out(oe_n_out),
        .dq_out(dq_out), .dq_oe_out(dq_oe_out), .dq_in(dq_in)
    );
    fcs_flash_model u_dev (
        .mclk_in(mclk_in), .addr_in(addr_out), .ce_n_in(ce_n_out), .we_n_in(we_n_out),
        .oe_n_in(oe_n_out), .dq_in(dq_out), .dq_oe_in(dq_oe_out), .dq_out(dq_in)
    );

    ////////////////////////////////////////////////////////////////////////////////
    // Clock and hang limit
    initial begin
        forever #2 mclk_in = ~mclk_in;
    end
    always @(posedge mclk_in) begin
        cycles <= cycles + 1;
        if (cycles == 20000) begin
            n_errors++;
            wrap_up();
        end
    end

    task automatic wrap_up();
        $display("checks %0d mismatches %0d", n_checks, n_errors);
        if (n_errors == 0 && n_checks > 0) $display("STATUS OK");
        else $display("STATUS NOT OK");
        $finish;
    endtask

    task automatic check(input string what, input logic [39:0] seen, input logic [39:0] exp);
        n_checks++;
        if (seen !== exp) begin
            n_errors++;
            $display("unexpected %s: expected %h seen %h", what, exp, seen);
        end
    endtask

    task automatic put(input logic [23:0] a, input logic [7:0] d);
        exp_q.push_back({a, 8'h00, d});
    endtask

    // Two unlock cycles, then, when last is set, a code at the first unlock address
    task automatic ent(input logic [7:0] code, input logic last);
        put({12'h000, byte_mode_in ? fcs_pkg::AD_B_UNLOCK1 : fcs_pkg::AD_W_UNLOCK1}, fcs_pkg::CD_UNLOCK1);
        put({12'h000, byte_mode_in ? fcs_pkg::AD_B_UNLOCK2 : fcs_pkg::AD_W_UNLOCK2}, fcs_pkg::CD_UNLOCK2);
        if (last) put({12'h000, byte_mode_in ? fcs_pkg::AD_B_UNLOCK1 : fcs_pkg::AD_W_UNLOCK1}, code);
    endtask

    ////////////////////////////////////////////////////////////////////////////////
    // One command, its buffer words, then the logged cycles
    task automatic run(input fcs_pkg::fcs_cmd_e c, input logic [23:0] a = 24'h000000,
                       input logic [15:0] d = 16'h0000, input logic [7:0] n = 8'h00);
        int k;
        exp_q.delete();
        u_dev.log_q.delete();
        case (c)
            fcs_pkg::FCS_CMD_PROGRAM: begin
                ent(fcs_pkg::CD_PROGRAM, 1'b1);
                exp_q.push_back({a, d});
            end
            fcs_pkg::FCS_CMD_BUF_PROGRAM: begin
                ent(8'h00, 1'b0);
                put(a, fcs_pkg::CD_BUF_LOAD);
                put(a, n);
                for (int i = 0; i <= n; i++) exp_q.push_back({a + 24'(i), 16'h1000 + 16'(i)});
                put(a, fcs_pkg::CD_BUF_CONFIRM);
            end
            fcs_pkg::FCS_CMD_SECTOR_ERASE: begin
                ent(fcs_pkg::CD_ERASE_SETUP, 1'b1);
                ent(8'h00, 1'b0);
                put(a, fcs_pkg::CD_SECTOR_ERASE);
            end
            fcs_pkg::FCS_CMD_CHIP_ERASE: begin
                ent(fcs_pkg::CD_ERASE_SETUP, 1'b1);
                ent(fcs_pkg::CD_CHIP_ERASE, 1'b1);
            end
            fcs_pkg::FCS_CMD_BUF_ABORT: ent(fcs_pkg::CD_RESET, 1'b1);
            fcs_pkg::FCS_CMD_DPD_ENTER: ent(fcs_pkg::CD_DPD_ENTER, 1'b1);
            fcs_pkg::FCS_CMD_LOCKREG_ENTER: ent(fcs_pkg::CD_LOCKREG_ENTER, 1'b1);
            fcs_pkg::FCS_CMD_NVPROT_ENTER: ent(fcs_pkg::CD_NVPROT_ENTER, 1'b1);
            fcs_pkg::FCS_CMD_FREEZE_ENTER: ent(fcs_pkg::CD_FREEZE_ENTER, 1'b1);
            fcs_pkg::FCS_CMD_QUERY: put({12'h000, byte_mode_in ? fcs_pkg::AD_B_QUERY : fcs_pkg::AD_W_QUERY}, 8'h98);
            fcs_pkg::FCS_CMD_SUSPEND: put(a, fcs_pkg::CD_SUSPEND);
            fcs_pkg::FCS_CMD_RESUME: put(a, fcs_pkg::CD_RESUME);
            fcs_pkg::FCS_CMD_DPD_EXIT: put(a, fcs_pkg::CD_DPD_EXIT);
            fcs_pkg::FCS_CMD_RESET: put(a, fcs_pkg::CD_RESET);
            fcs_pkg::FCS_CMD_LOCKREG_PROGRAM: begin
                put(a, fcs_pkg::CD_PROGRAM);
                exp_q.push_back({a, d});
            end
            fcs_pkg::FCS_CMD_SET_EXIT: begin
                put(a, fcs_pkg::CD_SET_EXIT1);
                put(a, fcs_pkg::CD_ZERO);
            end
            fcs_pkg::FCS_CMD_NVPROT_ERASE_ALL: begin
                put(a, fcs_pkg::CD_ERASE_SETUP);
                put(24'h000000, fcs_pkg::CD_SECTOR_ERASE);
            end
            fcs_pkg::FCS_CMD_NVPROT_SET, fcs_pkg::FCS_CMD_FREEZE_SET: begin
                put(a, fcs_pkg::CD_PROGRAM);
                put(a, fcs_pkg::CD_ZERO);
            end
            default: ;
        endcase
        // Taken at the next edge from idle
        @(posedge mclk_in);
        req_valid_in <= 1'b1;
        req_in <= '{c, a, d, n};
        @(posedge mclk_in);
        req_valid_in <= 1'b0;
        for (int i = 0; i <= n && c == fcs_pkg::FCS_CMD_BUF_PROGRAM; i++) begin
            buf_valid_in <= 1'b1;
            buf_addr_in <= a + 24'(i);
            buf_data_in <= 16'h1000 + 16'(i);
            do @(negedge mclk_in); while (buf_ready_out !== 1'b1);
            @(posedge mclk_in);
        end
        buf_valid_in <= 1'b0;
        k = 0;
        do begin @(negedge mclk_in); k++; end while (done_out !== 1'b1 && k < 500);
        check("done", 40'(done_out), 40'h1);
        check("cycle count", 40'(u_dev.log_q.size()), 40'(exp_q.size()));
        foreach (exp_q[i]) check("bus cycle", u_dev.log_q[i], exp_q[i]);
    endtask

    task automatic t_program_erase();
        for (int bm = 0; bm < 2; bm++) begin
            byte_mode_in <= bm[0];
            @(posedge mclk_in);
            run(fcs_pkg::FCS_CMD_PROGRAM, 24'h012340, 16'hBEEF, 8'h00);
            run(fcs_pkg::FCS_CMD_CHIP_ERASE);
            run(fcs_pkg::FCS_CMD_SECTOR_ERASE, 24'h230000);
            run(fcs_pkg::FCS_CMD_QUERY);
            run(fcs_pkg::FCS_CMD_RESET, 24'h000777);
            run(fcs_pkg::FCS_CMD_SUSPEND, 24'h123456);
            run(fcs_pkg::FCS_CMD_RESUME, 24'h00ABCD);
            run(fcs_pkg::FCS_CMD_DPD_ENTER);
            run(fcs_pkg::FCS_CMD_DPD_EXIT, 24'h3FFFFF);
        end
        $display("test single commands done");
    endtask

    task automatic t_buffer();
        run(fcs_pkg::FCS_CMD_BUF_PROGRAM, 24'h040000, 16'h0000, 8'h02);
        run(fcs_pkg::FCS_CMD_BUF_PROGRAM, 24'h050000, 16'h0000, 8'h1F);
        run(fcs_pkg::FCS_CMD_BUF_ABORT);
        $display("test buffered program done");
    endtask

    // Each protection set: enter, act, read, leave
    task automatic t_sets();
        u_dev.lock_r = 16'hA5C3;
        run(fcs_pkg::FCS_CMD_LOCKREG_ENTER);
        run(fcs_pkg::FCS_CMD_LOCKREG_PROGRAM, 24'h000010, 16'hFFFE, 8'h00);
        run(fcs_pkg::FCS_CMD_READ, 24'h000020);
        check("lock read", 40'(rd_data_out), 40'hA5C3);
        check("unprotected", 40'(prot_status_out), 40'h0);
        run(fcs_pkg::FCS_CMD_SET_EXIT);
        u_dev.lock_r = 16'h0000;
        run(fcs_pkg::FCS_CMD_NVPROT_ENTER);
        run(fcs_pkg::FCS_CMD_NVPROT_SET, 24'h070000);
        run(fcs_pkg::FCS_CMD_NVPROT_ERASE_ALL);
        run(fcs_pkg::FCS_CMD_READ, 24'h070000);
        check("protected", 40'(prot_status_out), 40'h1);
        run(fcs_pkg::FCS_CMD_SET_EXIT);
        u_dev.lock_r = 16'h0001;
        run(fcs_pkg::FCS_CMD_FREEZE_ENTER);
        run(fcs_pkg::FCS_CMD_FREEZE_SET);
        run(fcs_pkg::FCS_CMD_READ);
        check("freeze status", 40'(rd_data_out), 40'h1);
        run(fcs_pkg::FCS_CMD_SET_EXIT);
        $display("test protection sets done");
    endtask

    ////////////////////////////////////////////////////////////////////////////////
    // Main sequence
    initial begin
        repeat (2) @(posedge mclk_in);
        rst_in <= 1'b0;
        t_program_erase();
        t_buffer();
        t_sets();
        wrap_up();
    end
endmodule
